// file: hdl/sbs_pkg.sv
package sbs_pkg;

    // scan path widths
    localparam int IR_W    = 3;
    localparam int ID_W    = 32;
    localparam int CHAIN_W = 71;

    // instruction codes
    localparam logic [2:0] INSTR_EXTEST  = 3'h0;
    localparam logic [2:0] INSTR_IDCODE  = 3'h1;
    localparam logic [2:0] INSTR_SAMPLEZ = 3'h2;
    localparam logic [2:0] INSTR_RSVD3   = 3'h3;
    localparam logic [2:0] INSTR_SAMPLE  = 3'h4;
    localparam logic [2:0] INSTR_RSVD5   = 3'h5;
    localparam logic [2:0] INSTR_RSVD6   = 3'h6;
    localparam logic [2:0] INSTR_BYPASS  = 3'h7;

    // values after reset or capture
    localparam logic [2:0] IR_RESET_VALUE   = INSTR_IDCODE;
    localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;
    localparam logic       BYPASS_CAPTURE   = 1'b0;

    // identification word field positions
    localparam int ID_PRESENT_BIT = 0;
    localparam int ID_VENDOR_LSB  = 1;
    localparam int ID_DEVICE_LSB  = 12;
    localparam int ID_WIDTH_LSB   = 18;
    localparam int ID_DEPTH_LSB   = 24;
    localparam int ID_REV_LSB     = 29;

    // minimum tck period, in ns; the bench runs tck at a 48 ns period
    localparam int TCK_MIN_PERIOD_NS = 50;

    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SH_DR,
        TAP_EX1_DR,
        TAP_PAU_DR,
        TAP_EX2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SH_IR,
        TAP_EX1_IR,
        TAP_PAU_IR,
        TAP_EX2_IR,
        TAP_UPD_IR
    } sbs_tap_state_t;

endpackage

// file: hdl/sbs_pair_buffer.sv
`timescale 1ns/100ps
module sbs_pair_buffer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic                  wrPtr;
        logic                  rdPtr;
        logic [1:0]            count;
    } sbs_buf_state_t;

    sbs_buf_state_t s;
    sbs_buf_state_t next_s;
    logic           push;
    logic           pop;

    assign inReady  = (s.count != 2'h2);
    assign outValid = (s.count != 2'h0);
    assign outData  = s.slot[s.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.slot[s.wrPtr] = inData;
            next_s.wrPtr         = ~s.wrPtr;
        end
        if (pop)
        begin
            next_s.rdPtr = ~s.rdPtr;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 2'h1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 2'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    chk_buf_no_overfill : assert property (@(posedge mclk) disable iff (!rst_n)
        (s.count == 2'h2) && !pop |=> (s.count == 2'h2) && !inReady)
        else $error("buffer lost its full state");

endmodule

// file: hdl/sbs_tap.sv
// How it works
// - scan paths: 3-bit instruction, bypass bit, 32-bit id word, 71-cell chain
// - code 000 captures the ring, selects the chain, floats memory outputs
// - code 001 captures the id word and selects it; memory unaffected
// - code 010 captures the ring, selects the chain, floats output drivers
// - code 100 captures the ring, selects the chain, leaves outputs driven
// - code 111 selects the single bypass bit; memory unaffected
// - id word bit zero always reads one
// - id fields: revision, depth, width, device, vendor, in fixed positions
// - instruction presets to id code at reset and test-logic reset
// - capture-instruction loads the low two instruction bits with 01
// - chain msb sits next to tdi, lsb next to tdo
`timescale 1ns/100ps
module sbs_tap #(
    // arbitrary identity values
    parameter logic [2:0]  ID_REVISION = 3'h2,
    parameter logic [4:0]  ID_DEPTH    = 5'h06,
    parameter logic [5:0]  ID_WIDTH    = 6'h03,
    parameter logic [5:0]  ID_DEVICE   = 6'h15,
    parameter logic [10:0] ID_VENDOR   = 11'h055
) (
    // system clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // io ring snapshots from the memory side
    input  wire logic                        ringValid,
    output logic                             ringReady,
    input  wire logic [sbs_pkg::CHAIN_W-1:0] ringData,
    // output drive control to the memory side
    output logic                             memOutputsHiZ,
    // test access port
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    output logic                             tdo,
    output logic                             tdoOe
);

    localparam logic [sbs_pkg::ID_W-1:0] ID_WORD =
        {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_DEVICE, ID_VENDOR, 1'b1};

    // ---- system clock side ----
    typedef struct packed {
        logic                        busy;
        logic                        reqToggle;
        logic                        ackS1;
        logic                        ackS2;
        logic [sbs_pkg::CHAIN_W-1:0] hold;
        logic                        hizS1;
        logic                        hizS2;
        logic                        memHiZ;
    } sbs_sys_state_t;

    // ---- link clock side ----
    typedef struct packed {
        logic                        reqS1;
        logic                        reqS2;
        logic                        ackToggle;
        logic [sbs_pkg::CHAIN_W-1:0] ringSnap;
        sbs_pkg::sbs_tap_state_t     state;
        logic [sbs_pkg::IR_W-1:0]    instr;
        logic [sbs_pkg::IR_W-1:0]    irShift;
        logic                        bypassBit;
        logic [sbs_pkg::ID_W-1:0]    idShift;
        logic [sbs_pkg::CHAIN_W-1:0] chain;
        logic                        hizReq;
    } sbs_link_state_t;

    sbs_sys_state_t              sy;
    sbs_sys_state_t              next_sy;
    sbs_link_state_t             lk;
    sbs_link_state_t             next_lk;
    logic                        bufValid;
    logic                        bufReady;
    logic [sbs_pkg::CHAIN_W-1:0] bufData;
    logic                        rstS1;
    logic                        tckRstN;
    logic                        chainSel;
    logic                        idSel;
    logic                        tdoBit;

    // a stalled crossing backs up into the buffer and then the source
    sbs_pair_buffer #(
        .WIDTH    (sbs_pkg::CHAIN_W)
    ) u_ring_buffer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inValid  (ringValid),
        .inReady  (ringReady),
        .inData   (ringData),
        .outValid (bufValid),
        .outReady (bufReady),
        .outData  (bufData)
    );

    assign bufReady      = !sy.busy;
    assign memOutputsHiZ = sy.memHiZ;

    always_comb
    begin
        next_sy        = sy;
        next_sy.ackS1  = lk.ackToggle;
        next_sy.ackS2  = sy.ackS1;
        next_sy.hizS1  = lk.hizReq;
        next_sy.hizS2  = sy.hizS1;
        next_sy.memHiZ = sy.hizS2;
        // hold stays still while busy, so the link side reads it safely
        if (sy.busy && (sy.ackS2 == sy.reqToggle))
        begin
            next_sy.busy = 1'b0;
        end
        else if (!sy.busy && bufValid)
        begin
            next_sy.hold      = bufData;
            next_sy.reqToggle = ~sy.reqToggle;
            next_sy.busy      = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sy <= '0;
        end
        else
        begin
            sy <= next_sy;
        end
    end

    // reset reaches the link side through two flops
    always_ff @(posedge tck)
    begin
        rstS1   <= rst_n;
        tckRstN <= rstS1;
    end

    assign chainSel = (lk.instr == sbs_pkg::INSTR_EXTEST)
                   || (lk.instr == sbs_pkg::INSTR_SAMPLEZ)
                   || (lk.instr == sbs_pkg::INSTR_SAMPLE);
    assign idSel    = (lk.instr == sbs_pkg::INSTR_IDCODE);

    always_comb
    begin
        next_lk           = lk;
        next_lk.reqS1     = sy.reqToggle;
        next_lk.reqS2     = lk.reqS1;
        if (lk.reqS2 != lk.ackToggle)
        begin
            next_lk.ringSnap  = sy.hold;
            next_lk.ackToggle = lk.reqS2;
        end
        unique case (lk.state)
            sbs_pkg::TAP_RESET:
                next_lk.state = tms ? sbs_pkg::TAP_RESET : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_IDLE:
                next_lk.state = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_SEL_DR:
                next_lk.state = tms ? sbs_pkg::TAP_SEL_IR : sbs_pkg::TAP_CAP_DR;
            sbs_pkg::TAP_CAP_DR:
                next_lk.state = tms ? sbs_pkg::TAP_EX1_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_SH_DR:
                next_lk.state = tms ? sbs_pkg::TAP_EX1_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_EX1_DR:
                next_lk.state = tms ? sbs_pkg::TAP_UPD_DR : sbs_pkg::TAP_PAU_DR;
            sbs_pkg::TAP_PAU_DR:
                next_lk.state = tms ? sbs_pkg::TAP_EX2_DR : sbs_pkg::TAP_PAU_DR;
            sbs_pkg::TAP_EX2_DR:
                next_lk.state = tms ? sbs_pkg::TAP_UPD_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_UPD_DR:
                next_lk.state = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_SEL_IR:
                next_lk.state = tms ? sbs_pkg::TAP_RESET : sbs_pkg::TAP_CAP_IR;
            sbs_pkg::TAP_CAP_IR:
                next_lk.state = tms ? sbs_pkg::TAP_EX1_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_SH_IR:
                next_lk.state = tms ? sbs_pkg::TAP_EX1_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_EX1_IR:
                next_lk.state = tms ? sbs_pkg::TAP_UPD_IR : sbs_pkg::TAP_PAU_IR;
            sbs_pkg::TAP_PAU_IR:
                next_lk.state = tms ? sbs_pkg::TAP_EX2_IR : sbs_pkg::TAP_PAU_IR;
            sbs_pkg::TAP_EX2_IR:
                next_lk.state = tms ? sbs_pkg::TAP_UPD_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_UPD_IR:
                next_lk.state = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
        endcase
        unique case (lk.state)
            sbs_pkg::TAP_RESET:
                next_lk.instr = sbs_pkg::IR_RESET_VALUE;
            sbs_pkg::TAP_CAP_IR:
                next_lk.irShift = sbs_pkg::IR_CAPTURE_VALUE;
            sbs_pkg::TAP_SH_IR:
                next_lk.irShift = {tdi, lk.irShift[sbs_pkg::IR_W-1:1]};
            sbs_pkg::TAP_UPD_IR:
                next_lk.instr = lk.irShift;
            sbs_pkg::TAP_CAP_DR:
            begin
                next_lk.idShift   = ID_WORD;
                next_lk.bypassBit = sbs_pkg::BYPASS_CAPTURE;
                // the ring may be mid-transition; the last snapshot is used
                if (chainSel)
                begin
                    next_lk.chain = lk.ringSnap;
                end
            end
            sbs_pkg::TAP_SH_DR:
            begin
                // shift toward the lsb; reserved codes act as bypass
                if (chainSel)
                begin
                    next_lk.chain = {tdi, lk.chain[sbs_pkg::CHAIN_W-1:1]};
                end
                else if (idSel)
                begin
                    next_lk.idShift = {tdi, lk.idShift[sbs_pkg::ID_W-1:1]};
                end
                else
                begin
                    next_lk.bypassBit = tdi;
                end
            end
            default:
            begin
                next_lk.instr = lk.instr;
            end
        endcase
        // only the two floating codes float outputs
        next_lk.hizReq = (next_lk.instr == sbs_pkg::INSTR_EXTEST)
                      || (next_lk.instr == sbs_pkg::INSTR_SAMPLEZ);
    end

    always_ff @(posedge tck)
    begin
        if (!tckRstN)
        begin
            lk       <= '0;
            lk.instr <= sbs_pkg::IR_RESET_VALUE;
        end
        else
        begin
            lk <= next_lk;
        end
    end

    always_comb
    begin
        if (lk.state == sbs_pkg::TAP_SH_IR)
        begin
            tdoBit = lk.irShift[0];
        end
        else if (chainSel)
        begin
            tdoBit = lk.chain[0];
        end
        else if (idSel)
        begin
            tdoBit = lk.idShift[0];
        end
        else
        begin
            tdoBit = lk.bypassBit;
        end
    end

    // tdo changes on the falling edge so the far end samples it mid-cycle
    always_ff @(negedge tck)
    begin
        if (!tckRstN)
        begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end
        else
        begin
            tdo   <= tdoBit;
            tdoOe <= (lk.state == sbs_pkg::TAP_SH_IR)
                  || (lk.state == sbs_pkg::TAP_SH_DR);
        end
    end

    sequence seq_five_ones;
        tms [*5];
    endsequence

    sequence seq_load_float;
        (lk.state == sbs_pkg::TAP_UPD_IR)
            && ((lk.irShift == sbs_pkg::INSTR_EXTEST)
            || (lk.irShift == sbs_pkg::INSTR_SAMPLEZ));
    endsequence

    chk_tlr_entry : assert property (@(posedge tck) disable iff (!tckRstN)
        seq_five_ones |=> (lk.state == sbs_pkg::TAP_RESET)
                          ##1 (lk.instr == sbs_pkg::IR_RESET_VALUE))
        else $error("five tms ones did not reach reset with id code");

    chk_ir_capture : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_CAP_IR) |=> (lk.irShift[1:0] == 2'h1))
        else $error("capture-ir pattern wrong");

    chk_ir_update : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state != sbs_pkg::TAP_UPD_IR) && (lk.state != sbs_pkg::TAP_RESET)
        |=> $stable(lk.instr))
        else $error("instruction changed outside update");

    chk_id_capture : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_CAP_DR) && idSel
        |=> (lk.idShift[sbs_pkg::ID_PRESENT_BIT] == 1'b1)
            && (lk.idShift[sbs_pkg::ID_W-1:sbs_pkg::ID_REV_LSB] == ID_REVISION)
            && (lk.idShift[sbs_pkg::ID_DEPTH_LSB+:5] == ID_DEPTH)
            && (lk.idShift[sbs_pkg::ID_WIDTH_LSB+:6] == ID_WIDTH)
            && (lk.idShift[sbs_pkg::ID_DEVICE_LSB+:6] == ID_DEVICE)
            && (lk.idShift[sbs_pkg::ID_VENDOR_LSB+:11] == ID_VENDOR))
        else $error("id word fields wrong after capture");

    chk_ring_capture : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_CAP_DR) && chainSel
        |=> (lk.chain == $past(lk.ringSnap)))
        else $error("chain did not capture the ring");

    chk_chain_order : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_SH_DR) && chainSel
        |=> (lk.chain[sbs_pkg::CHAIN_W-1] == $past(tdi))
            && (lk.chain[sbs_pkg::CHAIN_W-2:0]
                == $past(lk.chain[sbs_pkg::CHAIN_W-1:1])))
        else $error("chain shift order wrong");

    chk_bypass_path : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_CAP_DR)
            && (lk.instr == sbs_pkg::INSTR_BYPASS)
        |=> (lk.bypassBit == 1'b0) && (tdoBit == 1'b0))
        else $error("bypass bit not captured low");

    chk_float_set : assert property (@(posedge tck) disable iff (!tckRstN)
        seq_load_float |=> lk.hizReq)
        else $error("floating code did not request high impedance");

    chk_drive_back : assert property (@(posedge tck) disable iff (!tckRstN)
        (lk.state == sbs_pkg::TAP_RESET) |=> !lk.hizReq)
        else $error("drive not restored under id code");

    chk_hiz_follow : assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(sy.hizS2) |=> memOutputsHiZ [*2])
        else $error("memory outputs not floated after request");

endmodule

// file: testbench/sbs_jtag_host.sv
`timescale 1ns/100ps
module sbs_jtag_host (
    // test access port, controller side
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdoOe
);
    localparam real HALF = 24.0;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period; tdo is taken at the rise, as set at the last fall
    task automatic step(input logic t, input logic d, output logic o,
                        output logic oe);
        tms = t;
        tdi = d;
        #(HALF);
        o = tdo;
        oe = tdoOe;
        tck = 1'b1;
        #(HALF);
        tck = 1'b0;
    endtask

    // tdi is not meaningful here, so it toggles instead of holding
    task automatic idle(input int n, input logic t);
        logic o;
        logic oe;
        repeat (n) step(t, ~tdi, o, oe);
    endtask

    task automatic loadIr(input logic [2:0] code, output logic [2:0] cap);
        logic       o;
        logic       oe;
        logic [2:0] cmd;
        cmd = code;
        if (code inside {sbs_pkg::INSTR_RSVD3, sbs_pkg::INSTR_RSVD5,
                         sbs_pkg::INSTR_RSVD6})
            cmd = sbs_pkg::INSTR_BYPASS;
        idle(2, 1'b1);
        idle(2, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            step(i == 2, cmd[i], o, oe);
            cap[i] = o;
        end
        idle(1, 1'b1);
        idle(1, 1'b0);
    endtask

    task automatic scanDr(input int n, input logic [79:0] din,
                          output logic [79:0] dout, output logic oeAll);
        logic o;
        logic oe;
        dout = '0;
        oeAll = 1'b1;
        idle(1, 1'b1);
        idle(2, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o, oe);
            dout[i] = o;
            oeAll = oeAll & oe;
        end
        idle(1, 1'b1);
        idle(1, 1'b0);
    endtask
endmodule

// file: testbench/sbs_tap_bench.sv
`timescale 1ns/100ps
module sbs_tap_bench;
    // arbitrary identity values
    localparam logic [2:0]  REV    = 3'h5;
    localparam logic [4:0]  DEPTH  = 5'h0C;
    localparam logic [5:0]  WIDTH  = 6'h21;
    localparam logic [5:0]  DEVICE = 6'h0A;
    localparam logic [10:0] VENDOR = 11'h3B2;
    localparam logic [31:0] ID_WORD = {REV, DEPTH, WIDTH, DEVICE, VENDOR,
                                       1'b1};

    typedef struct {
        logic [2:0] code;
        int         len;
        logic       hiz;
    } sbs_row_t;

    logic                        mclk;
    logic                        rst_n;
    logic                        ringValid;
    logic                        ringReady;
    logic [sbs_pkg::CHAIN_W-1:0] ringData;
    logic [sbs_pkg::CHAIN_W-1:0] ringNow;
    logic                        memOutputsHiZ;
    logic                        tck;
    logic                        tms;
    logic                        tdi;
    logic                        tdo;
    logic                        tdoOe;
    logic [2:0]                  cap;
    logic [79:0]                 din;
    logic [79:0]                 dout;
    logic [79:0]                 expCap;
    logic                        oe;
    int                          nMismatch;
    int                          totalChecks;
    sbs_row_t                    rows [5];

    sbs_tap #(
        .ID_REVISION (REV),
        .ID_DEPTH    (DEPTH),
        .ID_WIDTH    (WIDTH),
        .ID_DEVICE   (DEVICE),
        .ID_VENDOR   (VENDOR)
    ) uut (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .ringValid     (ringValid),
        .ringReady     (ringReady),
        .ringData      (ringData),
        .memOutputsHiZ (memOutputsHiZ),
        .tck           (tck),
        .tms           (tms),
        .tdi           (tdi),
        .tdo           (tdo),
        .tdoOe         (tdoOe)
    );

    sbs_jtag_host host (
        .tck   (tck),
        .tms   (tms),
        .tdi   (tdi),
        .tdo   (tdo),
        .tdoOe (tdoOe)
    );

    always #2.5 mclk = ~mclk;

    function automatic logic [70:0] word(input int i);
        return {7'(i), 64'hA5C3_0F1E_9B7D_2468 ^ {8{8'(i)}}};
    endfunction

    // captured bits come out first, then tdi delayed by the path length
    function automatic logic [79:0] expScan(input int len,
                                            input logic [79:0] c,
                                            input logic [79:0] d);
        return (c | (d << len)) & ((80'h1 << (len + 8)) - 80'h1);
    endfunction

    task automatic chkBit(input string what, input logic e, input logic g);
        totalChecks++;
        if (g !== e)
        begin
            nMismatch++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chkVec(input string what, input logic [79:0] e,
                          input logic [79:0] g);
        totalChecks++;
        if (g !== e)
        begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // valid is held until ready is seen high at a taking edge
    task automatic pushRing(input logic [70:0] w);
        int k;
        @(negedge mclk);
        ringValid = 1'b1;
        ringData = w;
        k = 0;
        while (ringReady !== 1'b1 && k < 1000)
        begin
            @(negedge mclk);
            k++;
        end
        if (k == 1000)
        begin
            nMismatch++;
            $display("BAD ringReady expected 1 seen %b", ringReady);
        end
        @(negedge mclk);
        ringValid = 1'b0;
        ringData = ~w;
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #100_000;
        nMismatch++;
        $display("BAD watchdog expected done seen hang");
        tallyAndFinish();
    end

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        ringValid = 1'b0;
        ringData = '0;
        nMismatch = 0;
        totalChecks = 0;
        din = {72'h0, 8'hC5};
        rows = '{'{sbs_pkg::INSTR_EXTEST, 71, 1'b1},
                 '{sbs_pkg::INSTR_SAMPLE, 71, 1'b0},
                 '{sbs_pkg::INSTR_SAMPLEZ, 71, 1'b1},
                 '{sbs_pkg::INSTR_BYPASS, 1, 1'b0},
                 '{sbs_pkg::INSTR_IDCODE, 32, 1'b0}};
        @(negedge mclk);
        // tck must run during reset for its synchroniser
        fork
            host.idle(5, 1'b1);
            repeat (12) @(negedge mclk);
        join
        chkBit("memOutputsHiZ reset", 1'b0, memOutputsHiZ); // drive on
        chkBit("ringReady reset", 1'b1, ringReady);
        chkBit("tdoOe reset", 1'b0, tdoOe);
        @(negedge mclk);
        rst_n = 1'b1;
        // fill the buffer while tck stands still, then let it drain
        pushRing(word(1));
        pushRing(word(2));
        pushRing(word(3));
        repeat (4) @(negedge mclk);
        chkBit("ringReady full", 1'b0, ringReady);
        fork
            pushRing(word(4));
            host.idle(24, 1'b1);
        join
        ringNow = word(4);
        host.idle(1, 1'b0);
        $display("test buffer done");
        host.scanDr(40, din, dout, oe);
        expCap = 80'(ID_WORD);
        chkVec("id after reset", expScan(32, expCap, din), dout); // preset
        $display("test reset instruction done");
        for (int i = 0; i < 5; i++)
        begin
            if (i > 0)
            begin
                ringNow = word(10 + i);
                pushRing(ringNow);
                host.idle(8, 1'b0);
            end
            host.loadIr(rows[i].code, cap);
            chkVec("ir capture", 80'(sbs_pkg::IR_CAPTURE_VALUE), 80'(cap)); // 01
            repeat (8) @(negedge mclk);
            chkBit("memOutputsHiZ", rows[i].hiz, memOutputsHiZ); // drive or float, per row
            host.scanDr(rows[i].len + 8, din, dout, oe);
            if (rows[i].len == 71)
                expCap = 80'(ringNow);
            else if (rows[i].len == 32)
                expCap = 80'(ID_WORD);
            else
                expCap = '0;
            chkVec("scan out", expScan(rows[i].len, expCap, din), dout); // paths
            chkBit("tdoOe shift", 1'b1, oe); // path driven
            chkBit("tdoOe idle", 1'b0, tdoOe);
            $display("test row %0d done", i);
        end
        // five tms ones must drop a floating code back to the id code
        host.loadIr(sbs_pkg::INSTR_EXTEST, cap);
        repeat (8) @(negedge mclk);
        chkBit("memOutputsHiZ extest", 1'b1, memOutputsHiZ); // float
        host.idle(5, 1'b1);
        host.idle(1, 1'b0);
        repeat (8) @(negedge mclk);
        chkBit("memOutputsHiZ tlr", 1'b0, memOutputsHiZ); // drive back
        host.scanDr(40, din, dout, oe);
        expCap = 80'(ID_WORD);
        chkVec("id after tlr", expScan(32, expCap, din), dout); // preset
        $display("test logic reset done");
        tallyAndFinish();
    end
endmodule
